// File: design/sub_dp_pkg.sv
// Shared constants and types of the subtract instruction datapath.
package sub_dp_pkg;

	// Instruction word layout.
	localparam int          INSTR_W      = 16;
	localparam int          DATA_W       = 8;
	localparam int          BANK_W       = 4;
	localparam int          DADDR_W      = BANK_W + DATA_W;
	localparam logic [7:0]  LIT_OPC      = 8'h08;
	localparam logic [5:0]  FILE_OPC     = 6'h17;
	localparam int          DEST_BIT     = 9;
	localparam int          ACCESS_BIT   = 8;

	// Access bank number used when the access bit is clear.
	localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;

	// Register offsets on the bus.
	localparam logic [7:0]  ACC_OFS      = 8'h00;
	localparam logic [7:0]  BANK_OFS     = 8'h04;
	localparam logic [7:0]  STATUS_OFS   = 8'h08;
	localparam logic [7:0]  COUNT_OFS    = 8'h0c;

	// Values after reset.
	localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
	localparam logic [BANK_W-1:0] BANK_RST = 4'h0;

	// Status register field positions.
	localparam int          STAT_BUSY_BIT = 8;

	// AHB-Lite codes.
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic        HRESP_OKAY    = 1'b0;

	typedef struct packed {
		logic negative;
		logic signed_wrap_flag;
		logic zero;
		logic half_carry_flag;
		logic carry;
	} flags_t;

	localparam flags_t FLAGS_RST = 5'h00;

	typedef struct packed {
		logic [DADDR_W-1:0] addr;
		logic               rd;
		logic               we;
		logic [DATA_W-1:0]  wdata;
	} dmem_req_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_Q1   = 5'b00010,
		ST_Q2   = 5'b00100,
		ST_Q3   = 5'b01000,
		ST_Q4   = 5'b10000
	} phase_t;

endpackage : sub_dp_pkg

// File: design/sub_dp.sv
// Subtract instruction datapath with an AHB-Lite register port.
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

// What this block does
// - The literal-subtract opcode computes the instruction's low byte minus the accumulator into the accumulator.
// - The file-subtract opcode computes the addressed data register minus the accumulator in two's complement.
// - With the destination bit clear the difference goes to the accumulator and the register is untouched.
// - With the destination bit set the difference is written back into the source data register.
// - With the access bit clear the fixed access bank is addressed and the bank pointer is ignored.
// - With the access bit set the address is the bank pointer joined to the 8-bit register field.
// - The literal subtract takes four phases: decode, read the immediate, process, write the accumulator.
// - The file subtract takes four phases: decode, read the register, process, write the destination last.
// - A positive difference sets carry and clears zero; negative copies bit 7 of the result.
// - Equal operands give zero with carry and zero set and negative clear.
// - A borrow clears carry and leaves the wrapped 8-bit result, with negative taken from its bit 7.
module sub_dp
	import sub_dp_pkg::*;
(
	// Clock, reset and clock enable.
	input  wire logic                          clk_i,
	input  wire logic                          nrst_i,
	input  wire logic                          ce_i,
	// Instruction from the sequencer.
	input  wire logic                          instr_valid_i,
	input  wire logic [sub_dp_pkg::INSTR_W-1:0] instr_i,
	output logic                               instr_ready_o,
	output logic                               done_o,
	// Banked data memory.
	output sub_dp_pkg::dmem_req_t              dmem_o,
	input  wire logic [sub_dp_pkg::DATA_W-1:0] dmem_rdata_i,
	// Core state.
	output logic [sub_dp_pkg::DATA_W-1:0]      acc_o,
	output sub_dp_pkg::flags_t                 flags_o,
	// AHB-Lite slave.
	input  wire logic                          hsel_i,
	input  wire logic [31:0]                   haddr_i,
	input  wire logic [1:0]                    htrans_i,
	input  wire logic                          hwrite_i,
	input  wire logic [2:0]                    hsize_i,
	input  wire logic [31:0]                   hwdata_i,
	input  wire logic                          hready_i,
	output logic [31:0]                        hrdata_o,
	output logic                               hreadyout_o,
	output logic                               hresp_o
);
	import sub_dp_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] res;
		flags_t            flags;
	} sub_out_t;

	// Minuend minus accumulator with the status of the subtraction.
	function automatic sub_out_t sub8(input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] a);
		logic [DATA_W:0] full;
		logic [4:0]      low;
		sub_out_t        o;
		// Adding the inverted accumulator plus one leaves the no-borrow carry in the top bit.
		full = {1'b0, m} + {1'b0, ~a} + 9'h001;
		low  = {1'b0, m[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
		o.res                    = full[DATA_W-1:0];
		o.flags.carry            = full[DATA_W];
		o.flags.half_carry_flag  = low[4];
		o.flags.zero             = (full[DATA_W-1:0] == 8'h00);
		o.flags.negative         = full[DATA_W-1];
		o.flags.signed_wrap_flag = (m[7] != a[7]) && (full[7] != m[7]);
		return o;
	endfunction : sub8

	// Match of a bus offset against the offset of one register.
	function automatic logic ofs_hit(input logic [7:0] ofs, input logic [7:0] reg_ofs);
		return (ofs == reg_ofs);
	endfunction : ofs_hit

	// Phase, operand, architectural and bus state.
	phase_t                 phase_r;
	phase_t                 phase_nxt;
	logic [INSTR_W-1:0]     instr_r;
	logic [DATA_W-1:0]      opnd_r;
	logic [DATA_W-1:0]      res_r;
	flags_t                 res_flags_r;
	logic [DATA_W-1:0]      acc_r;
	flags_t                 flags_r;
	logic [BANK_W-1:0]      bank_r;
	logic [31:0]            count_r;
	dmem_req_t              dmem_r;
	logic                   ready_r;
	logic                   done_r;
	logic [31:0]            hrdata_r;
	logic                   dwr_r;
	logic [7:0]             daddr_r;
	logic                   hready_r;
	logic                   hresp_r;

	// Decode of the held instruction word.
	wire logic              is_lit   = (instr_r[15:8] == LIT_OPC);
	wire logic              is_file  = (instr_r[15:10] == FILE_OPC);
	wire logic              to_file  = is_file && instr_r[DEST_BIT];
	wire logic              use_bank = instr_r[ACCESS_BIT];
	wire logic [BANK_W-1:0] bank_sel = use_bank ? bank_r : ACCESS_BANK;
	wire logic [DADDR_W-1:0] faddr   = {bank_sel, instr_r[7:0]};
	wire logic [DATA_W-1:0] opnd_nxt = is_lit ? instr_r[7:0] : dmem_rdata_i;
	wire sub_out_t          sub_res  = sub8(opnd_r, acc_r);
	// Only a decoded subtract commits, so an unknown opcode walks the phases and changes nothing.
	wire logic              commit   = (phase_r == ST_Q4) && (is_lit || is_file);
	wire logic              acc_wr   = commit && !to_file;
	wire logic              take     = (phase_r == ST_IDLE) && instr_valid_i;

	// Bus decode.
	wire logic              bus_req  = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
	wire logic              bus_wr   = bus_req && hwrite_i;
	wire logic [7:0]        bus_ofs  = haddr_i[7:0];
	// Register selection from the live address phase.
	wire logic              hit_acc    = ofs_hit(bus_ofs, ACC_OFS);
	wire logic              hit_bank   = ofs_hit(bus_ofs, BANK_OFS);
	wire logic              hit_status = ofs_hit(bus_ofs, STATUS_OFS);
	wire logic              hit_count  = ofs_hit(bus_ofs, COUNT_OFS);
	wire logic              busy       = (phase_r != ST_IDLE);
	wire logic [31:0]       status_w = {23'h000000, busy, 3'h0, flags_r};
	wire logic [31:0]       rd_mux   = hit_acc    ? {24'h000000, acc_r} :
	                                   hit_bank   ? {28'h0000000, bank_r} :
	                                   hit_status ? status_w :
	                                   hit_count  ? count_r : 32'h00000000;
	wire logic              bus_acc  = dwr_r && ofs_hit(daddr_r, ACC_OFS);
	wire logic              bus_bank = dwr_r && ofs_hit(daddr_r, BANK_OFS);

	// Phase sequence; every instruction walks all four phases.
	always_comb
	begin
		phase_nxt = phase_r;
		unique case (phase_r)
			ST_IDLE: phase_nxt = take ? ST_Q1 : ST_IDLE;
			ST_Q1:   phase_nxt = ST_Q2;
			ST_Q2:   phase_nxt = ST_Q3;
			ST_Q3:   phase_nxt = ST_Q4;
			ST_Q4:   phase_nxt = ST_IDLE;
			default: phase_nxt = ST_IDLE;
		endcase
	end

	// Phase register.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			phase_r <= ST_IDLE;
		else if (ce_i)
			phase_r <= phase_nxt;
	end

	// Idle indication and the one-cycle completion pulse.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ready_r <= 1'b1;
			done_r  <= 1'b0;
		end
		else if (ce_i)
		begin
			ready_r <= (phase_nxt == ST_IDLE);
			done_r  <= (phase_r == ST_Q4);
		end
	end

	// The instruction word is held through all four phases.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			instr_r <= 16'h0000;
		else if (ce_i && take)
			instr_r <= instr_i;
	end

	// Operand capture in the read phase.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			opnd_r <= 8'h00;
		else if (ce_i && (phase_r == ST_Q2))
			opnd_r <= opnd_nxt;
	end

	// Result and its status are formed in the process phase.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			res_r       <= 8'h00;
			res_flags_r <= FLAGS_RST;
		end
		else if (ce_i && (phase_r == ST_Q3))
		begin
			res_r       <= sub_res.res;
			res_flags_r <= sub_res.flags;
		end
	end

	// Data memory requests: read in the second phase, write back in the fourth.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			dmem_r <= '0;
		else if (ce_i)
		begin
			dmem_r.rd <= (phase_r == ST_Q1) && is_file;
			dmem_r.we <= (phase_r == ST_Q3) && to_file;
			if (phase_r == ST_Q1)
				dmem_r.addr <= faddr;
			if (phase_r == ST_Q3)
				dmem_r.wdata <= sub_res.res;
		end
	end

	// Accumulator; an instruction write beats a bus write in the same cycle, which is then lost.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			acc_r <= ACC_RST;
		else if (ce_i)
		begin
			if (acc_wr)
				acc_r <= res_r;
			else if (bus_acc)
				acc_r <= hwdata_i[DATA_W-1:0];
		end
	end

	// Flags and the commit counter change only when a subtract completes.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			flags_r <= FLAGS_RST;
			count_r <= 32'h00000000;
		end
		else if (ce_i && commit)
		begin
			flags_r <= res_flags_r;
			count_r <= count_r + 32'h00000001;
		end
	end

	// Bank pointer, written from the bus only.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			bank_r <= BANK_RST;
		else if (ce_i && bus_bank)
			bank_r <= hwdata_i[BANK_W-1:0];
	end

	// Zero-wait AHB-Lite slave: the address phase is latched for the data phase.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			dwr_r   <= 1'b0;
			daddr_r <= 8'h00;
		end
		else if (ce_i)
		begin
			dwr_r <= bus_wr;
			if (bus_req)
				daddr_r <= bus_ofs;
		end
	end

	// Read data is captured at the address phase and stands through the data phase.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			hrdata_r <= 32'h00000000;
		else if (ce_i && bus_req)
			hrdata_r <= hwrite_i ? 32'h00000000 : rd_mux;
	end

	// Bus response flags; the slave never stalls and never signals an error.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			hready_r <= 1'b1;
			hresp_r  <= HRESP_OKAY;
		end
		else if (ce_i)
		begin
			hready_r <= 1'b1;
			hresp_r  <= HRESP_OKAY;
		end
	end

	assign instr_ready_o = ready_r;
	assign done_o        = done_r;
	assign dmem_o        = dmem_r;
	assign acc_o         = acc_r;
	assign flags_o       = flags_r;
	assign hrdata_o      = hrdata_r;
	assign hreadyout_o   = hready_r;
	assign hresp_o       = hresp_r;

endmodule : sub_dp

// File: sim/sub_dp_checker.sv
// Port assertions of the subtract datapath.
`timescale 1ns/1ps
module sub_dp_checker
	import sub_dp_pkg::*;
(
	input wire logic                  clk_i,
	input wire logic                  nrst_i,
	input wire logic                  ce_i,
	input wire logic                  instr_valid_i,
	input wire logic [15:0]           instr_i,
	input wire logic                  instr_ready_o,
	input wire logic                  done_o,
	input wire sub_dp_pkg::dmem_req_t dmem_o,
	input wire logic [7:0]            acc_o,
	input wire sub_dp_pkg::flags_t    flags_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i || !ce_i);
	wire t = ce_i && instr_valid_i && instr_ready_o;
	wire l = t && instr_i[15:8] == LIT_OPC;
	wire f = t && instr_i[15:10] == FILE_OPC;
	done_at5_a: assert property (t |-> ##5 done_o) else $error("done");
	busy_span_a: assert property (t |=> !instr_ready_o[*4] ##1 instr_ready_o) else $error("busy");
	lit_nomem_a: assert property (l |=> (!dmem_o.rd && !dmem_o.we)[*5]) else $error("mem");
	file_read_a: assert property (f |-> ##2 dmem_o.rd ##1 !dmem_o.rd) else $error("rd");
	bank_fix_a: assert property (f && !instr_i[ACCESS_BIT] |->
		##2 dmem_o.addr == {ACCESS_BANK, $past(instr_i[7:0], 2)}) else $error("addr");
	dest_we_a: assert property (f |-> ##4 dmem_o.we == $past(instr_i[DEST_BIT], 4)) else $error("we");
	acc_keep_a: assert property (f && instr_i[DEST_BIT] |=> $stable(acc_o)[*5]) else $error("acc");
	zero_flags_a: assert property (flags_o.zero |-> flags_o.carry && !flags_o.negative) else $error("z");
endmodule : sub_dp_checker

bind sub_dp sub_dp_checker chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i),
	.instr_i(instr_i), .instr_ready_o(instr_ready_o), .done_o(done_o), .dmem_o(dmem_o), .acc_o(acc_o),
	.flags_o(flags_o));

// File: sim/dmem_model.sv
// Banked data memory model at the datapath's far side.
`timescale 1ns/1ps
module dmem_model
	import sub_dp_pkg::*;
(
	input wire logic                  clk_i,
	input wire sub_dp_pkg::dmem_req_t req_i,
	output logic [7:0]                rdata_o
);
	logic [7:0] mem [0:4095];
	// Outside a read the lines show the inverse so stale data never passes.
	assign rdata_o = req_i.rd ? mem[req_i.addr] : ~mem[req_i.addr];
	always @(posedge clk_i)
		if (req_i.we)
			mem[req_i.addr] <= req_i.wdata;
endmodule : dmem_model

// File: sim/tb.sv
// Self-checking testbench of the subtract datapath.
`timescale 1ns/1ps
module tb;
	import sub_dp_pkg::*;
	logic        clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        ce_i = 1'b1;
	logic        instr_valid_i = 1'b0;
	logic [15:0] instr_i = 16'h0000;
	logic        hsel_i = 1'b0;
	logic        hwrite_i = 1'b0;
	logic [1:0]  htrans_i = 2'h0;
	logic [2:0]  hsize_i = 3'h2;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic [31:0] hrdata_o, rd;
	logic        instr_ready_o, done_o, hreadyout_o, hresp_o;
	logic [7:0]  acc_o, dmem_rdata_i;
	flags_t      flags_o;
	dmem_req_t   dmem_o;
	int          mismatches, checks_done, cyc;

	sub_dp dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
		.instr_ready_o(instr_ready_o), .done_o(done_o), .dmem_o(dmem_o), .dmem_rdata_i(dmem_rdata_i),
		.acc_o(acc_o), .flags_o(flags_o), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
		.hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
		.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));
	dmem_model mem_u (.clk_i(clk_i), .req_i(dmem_o), .rdata_o(dmem_rdata_i));

	initial forever #2 clk_i = ~clk_i;

	function automatic flags_t ef(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] r;
		r = a - b;
		return {r[7], a[7] != b[7] && r[7] != a[7], r == 8'h00, a[3:0] >= b[3:0], a >= b};
	endfunction : ef

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel_i <= 1'b1;
		htrans_i <= HTRANS_NONSEQ;
		hwrite_i <= w;
		haddr_i <= a;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
		chk(hresp_o, HRESP_OKAY);
	endtask : bus

	task automatic run(input logic [15:0] ins, input int hold);
		int n;
		@(posedge clk_i);
		instr_valid_i <= 1'b1;
		instr_i <= ins;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		if (hold > 0)
		begin
			// A low clock enable must freeze the instruction in flight.
			ce_i <= 1'b0;
			repeat (hold) @(posedge clk_i);
			chk({done_o, instr_ready_o}, 2'b00);
			ce_i <= 1'b1;
		end
		// Edges counted from the taking edge, or from the last held edge, to the one that samples done high.
		for (n = 0; n < 20 && done_o !== 1'b1; n++)
			@(posedge clk_i);
		chk(n, 5);
	endtask : run

	task automatic t_lit();
		logic [7:0] k [4] = '{8'h02, 8'h02, 8'h02, 8'h80};
		logic [7:0] w [4] = '{8'h01, 8'h02, 8'h03, 8'h01};
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, ACC_OFS, w[i]);
			run({LIT_OPC, k[i]}, (i == 3) ? 3 : 0);
			chk(acc_o, 8'(k[i] - w[i]));
			chk(flags_o, ef(k[i], w[i]));
			bus(1'b0, STATUS_OFS, 0);
			chk(rd, 32'(ef(k[i], w[i])));
		end
		$display("literal test done");
	endtask : t_lit

	task automatic t_file();
		logic [7:0] r [4] = '{8'h03, 8'h02, 8'h01, 8'h19};
		logic [7:0] w [4] = '{8'h02, 8'h02, 8'h02, 8'h0d};
		logic [11:0] ad;
		logic [7:0] f, res;
		bus(1'b1, BANK_OFS, 32'h5);
		for (int i = 0; i < 4; i++)
		begin
			f = 8'h30 + 8'(i);
			ad = {i[1] ? 4'h5 : ACCESS_BANK, f};
			mem_u.mem[ad] = r[i];
			// A decoy in the other bank exposes a wrong bank choice.
			mem_u.mem[{i[1] ? ACCESS_BANK : 4'h5, f}] = 8'haa;
			res = r[i] - w[i];
			bus(1'b1, ACC_OFS, w[i]);
			run({FILE_OPC, i[0], i[1], f}, 0);
			chk(acc_o, i[0] ? w[i] : res);
			chk(mem_u.mem[ad], i[0] ? res : r[i]);
			chk(flags_o, ef(r[i], w[i]));
		end
		bus(1'b0, 32'h40, 0);
		chk(rd, 0);
		bus(1'b0, BANK_OFS, 0);
		chk(rd, 32'h00000005);
		bus(1'b0, COUNT_OFS, 0);
		chk(rd, 32'h00000008);
		$display("file test done");
	endtask : t_file

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			end_of_test();
		end
	end

	initial
	begin
		repeat (4) @(posedge clk_i);
		chk(acc_o, ACC_RST);
		chk(flags_o, FLAGS_RST);
		chk({instr_ready_o, done_o, hreadyout_o, hresp_o, dmem_o.rd, dmem_o.we}, 6'b101000);
		chk(hrdata_o, 32'h00000000);
		nrst_i <= 1'b1;
		t_lit();
		t_file();
		end_of_test();
	end
endmodule : tb
